//--- verilog/csp_pkg.sv
package csp_pkg;
  // clock and time base
  localparam int CLK_HZ = 25_000_000;
  localparam int CLK_PERIOD_NS = 40;
  localparam int MS_NS = 1_000_000;
  localparam int CYC_PER_MS = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // configuration word offsets
  localparam logic [4:0] A_FAIL_LIMIT = 5'h00;
  localparam logic [4:0] A_ENABLE = 5'h01;
  localparam logic [4:0] A_END_SEL = 5'h02;
  localparam logic [4:0] A_RATE = 5'h03;
  localparam logic [4:0] A_PARITY = 5'h04;
  localparam logic [4:0] A_DATA_BITS = 5'h05;
  localparam logic [4:0] A_STOP_BITS = 5'h06;
  localparam logic [4:0] A_RTS_LEAD = 5'h07;
  localparam logic [4:0] A_RTS_TRAIL = 5'h08;
  localparam logic [4:0] A_FLOW = 5'h09;
  localparam logic [4:0] A_TERM_CNT = 5'h0a;
  localparam logic [4:0] A_TERM0 = 5'h0b;
  localparam logic [4:0] A_PKT_LEN = 5'h11;
  localparam logic [4:0] A_RX_TIMEOUT = 5'h12;
  localparam logic [4:0] A_RX_GAP = 5'h13;
  localparam logic [4:0] A_TX_TIMEOUT = 5'h14;
  localparam int NUM_WORDS = 21;
  localparam int NUM_TERM = 12;
  // reset values
  localparam logic [15:0] RST_RATE = 16'h2580;
  localparam logic [15:0] RST_DATA_BITS = 16'h0008;
  localparam logic [15:0] RST_STOP_BITS = 16'h0001;
  localparam logic [15:0] RST_OTHER = 16'h0000;
  // field positions and codes
  localparam int SEL_TERM = 0;
  localparam int SEL_MSG_TO = 1;
  localparam int SEL_GAP_TO = 2;
  localparam int SEL_PKT_LEN = 3;
  localparam logic [15:0] EN_ON = 16'h0001;
  localparam logic [15:0] PAR_NONE = 16'h0000;
  localparam logic [15:0] PAR_ODD = 16'h0001;
  localparam logic [15:0] PAR_EVEN = 16'h0002;
  localparam logic [15:0] PAR_MARK = 16'h0003;
  localparam logic [15:0] PAR_SPACE = 16'h0004;
  localparam logic [15:0] FLOW_RTS_CTS = 16'h0001;
  localparam logic [15:0] FLOW_DTR_DSR = 16'h0002;
  localparam logic [15:0] FLOW_XON_XOFF = 16'h0003;
  localparam logic [15:0] STOP_TWO = 16'h0002;
  localparam logic [7:0] CH_XON = 8'h11;
  localparam logic [7:0] CH_XOFF = 8'h13;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_WIDTH = 9;

  function automatic logic [15:0] cfg_reset(input int idx);
    case (idx)
      3: cfg_reset = RST_RATE;
      5: cfg_reset = RST_DATA_BITS;
      6: cfg_reset = RST_STOP_BITS;
      default: cfg_reset = RST_OTHER;
    endcase
  endfunction

  // clock cycles per bit for each supported rate
  function automatic logic [17:0] bit_cycles(input logic [15:0] rate);
    case (rate)
      16'h006e: bit_cycles = 18'(CLK_HZ / 110);
      16'h0096: bit_cycles = 18'(CLK_HZ / 150);
      16'h012c: bit_cycles = 18'(CLK_HZ / 300);
      16'h0258: bit_cycles = 18'(CLK_HZ / 600);
      16'h04b0: bit_cycles = 18'(CLK_HZ / 1200);
      16'h0960: bit_cycles = 18'(CLK_HZ / 2400);
      16'h12c0: bit_cycles = 18'(CLK_HZ / 4800);
      16'h4b00: bit_cycles = 18'(CLK_HZ / 19200);
      16'h7080: bit_cycles = 18'(CLK_HZ / 28800);
      16'h9600: bit_cycles = 18'(CLK_HZ / 38400);
      16'he100: bit_cycles = 18'(CLK_HZ / 57600);
      16'h0073: bit_cycles = 18'(CLK_HZ / 115200);
      default: bit_cycles = 18'(CLK_HZ / 9600);
    endcase
  endfunction
endpackage

//--- verilog/csp_fifo.sv
`timescale 1ns/1ps
module csp_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wr_q, wr_d, rd_q, rd_d;
  logic push, pop;

  assign in_ready = (wr_q - rd_q) != (AW+1)'(DEPTH);
  assign out_valid = wr_q != rd_q;
  assign out_data = mem_q[rd_q[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    wr_d = push ? wr_q + 1'b1 : wr_q;
    rd_d = pop ? rd_q + 1'b1 : rd_q;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_data;
    end
  end
endmodule

//--- verilog/csp_ms_timer.sv
`timescale 1ns/1ps
module csp_ms_timer #(
  parameter int CYC_PER_MS = 25000
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic start,
  input wire logic stop,
  input wire logic [15:0] ms,
  output logic expired
);
  logic [15:0] cnt_q, cnt_d;
  logic [15:0] pre_q, pre_d;
  logic run_q, run_d;

  assign expired = run_q && (cnt_q == 16'h0000);

  always_comb begin
    cnt_d = cnt_q;
    pre_d = pre_q;
    run_d = run_q;
    if (stop) begin
      run_d = 1'b0;
    end else if (start) begin
      cnt_d = ms;
      pre_d = 16'(CYC_PER_MS - 1);
      run_d = 1'b1;
    end else if (run_q && cnt_q != 16'h0000) begin
      if (pre_q == 16'h0000) begin
        pre_d = 16'(CYC_PER_MS - 1);
        cnt_d = cnt_q - 16'h0001;
      end else begin
        pre_d = pre_q - 16'h0001;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= 16'h0000;
      pre_q <= 16'h0000;
      run_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      pre_q <= pre_d;
      run_q <= run_d;
    end
  end
endmodule

//--- verilog/csp_serial_port.sv
// Behaviour
// - stop ports after limit of failed transfers
// - port idle at enable 0, runs at 1
// - end select bits: term, msg, gap, length
// - end select zero means stream mode
// - line rate given as numeric bit rate, 115 for 115200
// - parity code none odd even mark space
// - five to eight data bits
// - one or two stop bits sent
// - wait lead milliseconds after raising rts
// - wait trail milliseconds before dropping rts
// - flow control none, rts/cts, dtr/dsr, xon/xoff
// - termination count zero to twelve used
// - twelve termination chars packed in words
// - message timeout from first character
// - gap timeout between characters
// - end message at packet length
// - abort message past transmit timeout
`timescale 1ns/1ps
module csp_serial_port
  import csp_pkg::*;
#(
  parameter int CYC_PER_MS_P = csp_pkg::CYC_PER_MS
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic cfg_we,
  input wire logic [4:0] cfg_addr,
  input wire logic [15:0] cfg_wdata,
  output logic [15:0] cfg_rdata,
  input wire logic xfer_done,
  input wire logic xfer_ok,
  output logic ports_halted,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  output logic tx_abort,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_end,
  output logic rx_parity_err,
  output logic txd,
  input wire logic rxd,
  output logic rts,
  input wire logic cts,
  output logic dtr,
  input wire logic dsr
);
  import csp_pkg::*;

  typedef enum logic [2:0] {
    T_IDLE = 3'b000, T_LEAD = 3'b001, T_WAIT = 3'b010,
    T_SHIFT = 3'b011, T_TRAIL = 3'b100, T_DROP = 3'b101
  } csp_tx_type;
  typedef enum logic [1:0] {
    R_IDLE = 2'b00, R_START = 2'b01, R_BITS = 2'b10
  } csp_rx_type;

  // configuration words
  logic [15:0] cfg_q [NUM_WORDS];
  logic [15:0] cfg_d [NUM_WORDS];
  logic [15:0] rdata_q, rdata_d;
  logic [15:0] fail_q, fail_d;

  always_comb begin
    for (int i = 0; i < NUM_WORDS; i++) begin
      cfg_d[i] = cfg_q[i];
    end
    if (cfg_we && cfg_addr < 5'(NUM_WORDS)) begin
      cfg_d[cfg_addr] = cfg_wdata;
    end
    rdata_d = (cfg_addr < 5'(NUM_WORDS)) ? cfg_q[cfg_addr] : 16'h0000;
    fail_d = fail_q;
    if (xfer_done) begin
      if (xfer_ok) begin
        fail_d = 16'h0000;
      end else if (fail_q != 16'hffff) begin
        fail_d = fail_q + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < NUM_WORDS; i++) begin
        cfg_q[i] <= cfg_reset(i);
      end
      rdata_q <= 16'h0000;
      fail_q <= 16'h0000;
    end else begin
      for (int i = 0; i < NUM_WORDS; i++) begin
        cfg_q[i] <= cfg_d[i];
      end
      rdata_q <= rdata_d;
      fail_q <= fail_d;
    end
  end

  assign cfg_rdata = rdata_q;

  // decoded configuration
  logic halted, active, par_on, stop2, flow_ok;
  logic [3:0] nbits, frame_len;
  logic [7:0] dmask;
  logic [17:0] bit_div;
  logic [15:0] flow, parity, end_sel;
  logic xoff_q, xoff_d;

  assign halted = cfg_q[A_FAIL_LIMIT] != 16'h0000 && fail_q >= cfg_q[A_FAIL_LIMIT];
  assign active = cfg_q[A_ENABLE] == EN_ON && !halted;
  assign ports_halted = halted;
  assign bit_div = bit_cycles(cfg_q[A_RATE]);
  assign parity = cfg_q[A_PARITY];
  assign flow = cfg_q[A_FLOW];
  assign end_sel = cfg_q[A_END_SEL];
  assign par_on = parity != PAR_NONE && parity <= PAR_SPACE;
  assign stop2 = cfg_q[A_STOP_BITS] == STOP_TWO;
  assign nbits = (cfg_q[A_DATA_BITS] >= 16'h0005 && cfg_q[A_DATA_BITS] <= 16'h0008) ?
    cfg_q[A_DATA_BITS][3:0] : 4'h8;
  assign dmask = 8'hff >> (4'h8 - nbits);
  assign frame_len = 4'h1 + nbits + {3'h0, par_on} + (stop2 ? 4'h2 : 4'h1);

  always_comb begin
    case (flow)
      FLOW_RTS_CTS: flow_ok = cts;
      FLOW_DTR_DSR: flow_ok = dsr;
      FLOW_XON_XOFF: flow_ok = !xoff_q;
      default: flow_ok = 1'b1;
    endcase
  end
  assign dtr = active;

  function automatic logic par_bit(input logic [7:0] d, input logic [15:0] code);
    case (code)
      PAR_ODD: par_bit = ~^d;
      PAR_EVEN: par_bit = ^d;
      PAR_MARK: par_bit = 1'b1;
      default: par_bit = 1'b0;
    endcase
  endfunction

  // transmit buffer and timers
  logic f_valid, f_pop;
  logic [8:0] f_data;
  logic dly_start, dly_exp, tto_start, tto_exp;
  logic [15:0] dly_ms;

  csp_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk), .resetn(resetn),
    .in_valid(tx_valid), .in_ready(tx_ready), .in_data({tx_last, tx_data}),
    .out_valid(f_valid), .out_ready(f_pop), .out_data(f_data)
  );
  csp_ms_timer #(.CYC_PER_MS(CYC_PER_MS_P)) u_dly (
    .clk(clk), .resetn(resetn), .start(dly_start), .stop(1'b0),
    .ms(dly_ms), .expired(dly_exp)
  );
  csp_ms_timer #(.CYC_PER_MS(CYC_PER_MS_P)) u_tto (
    .clk(clk), .resetn(resetn), .start(tto_start), .stop(1'b0),
    .ms(cfg_q[A_TX_TIMEOUT]), .expired(tto_exp)
  );

  // transmitter
  csp_tx_type tst_q, tst_d;
  logic [11:0] tsh_q, tsh_d, frame;
  logic [3:0] tbit_q, tbit_d;
  logic [17:0] tdiv_q, tdiv_d;
  logic tlast_q, tlast_d, txd_q, txd_d, rts_q, rts_d, abort_q, abort_d;

  always_comb begin
    frame = 12'hfff;
    frame[0] = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (4'(i) < nbits) frame[i + 1] = f_data[i];
    end
    if (par_on) frame[nbits + 4'h1] = par_bit(f_data[7:0] & dmask, parity);
  end

  always_comb begin
    tst_d = tst_q;
    tsh_d = tsh_q;
    tbit_d = tbit_q;
    tdiv_d = tdiv_q;
    tlast_d = tlast_q;
    txd_d = txd_q;
    rts_d = rts_q;
    abort_d = 1'b0;
    f_pop = 1'b0;
    dly_start = 1'b0;
    dly_ms = cfg_q[A_RTS_LEAD];
    tto_start = 1'b0;
    if (!active && tst_q != T_IDLE) begin
      tst_d = T_IDLE;
      rts_d = 1'b0;
      txd_d = 1'b1;
    end else begin
      case (tst_q)
        T_IDLE: begin
          txd_d = 1'b1;
          if (active && f_valid) begin
            rts_d = 1'b1;
            dly_start = 1'b1;
            tto_start = 1'b1;
            tst_d = T_LEAD;
          end
        end
        T_LEAD: begin
          if (dly_exp) tst_d = T_WAIT;
        end
        T_WAIT: begin
          if (cfg_q[A_TX_TIMEOUT] != 16'h0000 && tto_exp) begin
            abort_d = 1'b1;
            tst_d = T_DROP;
          end else if (f_valid && flow_ok) begin
            f_pop = 1'b1;
            tsh_d = frame;
            txd_d = frame[0];
            tbit_d = 4'h0;
            tdiv_d = bit_div - 18'h0_0001;
            tlast_d = f_data[8];
            tst_d = T_SHIFT;
          end
        end
        T_SHIFT: begin
          if (tdiv_q != 18'h0_0000) begin
            tdiv_d = tdiv_q - 18'h0_0001;
          end else if (tbit_q == frame_len - 4'h1) begin
            if (tlast_q) begin
              dly_start = 1'b1;
              dly_ms = cfg_q[A_RTS_TRAIL];
              tst_d = T_TRAIL;
            end else begin
              tst_d = T_WAIT;
            end
          end else begin
            tsh_d = {1'b1, tsh_q[11:1]};
            txd_d = tsh_q[1];
            tbit_d = tbit_q + 4'h1;
            tdiv_d = bit_div - 18'h0_0001;
          end
        end
        T_TRAIL: begin
          if (dly_exp) begin
            rts_d = 1'b0;
            tst_d = T_IDLE;
          end
        end
        T_DROP: begin
          if (f_valid) begin
            f_pop = 1'b1;
            if (f_data[8]) begin
              dly_start = 1'b1;
              dly_ms = cfg_q[A_RTS_TRAIL];
              tst_d = T_TRAIL;
            end
          end
        end
        default: tst_d = T_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tst_q <= T_IDLE;
      tsh_q <= 12'hfff;
      tbit_q <= 4'h0;
      tdiv_q <= 18'h0_0000;
      tlast_q <= 1'b0;
      txd_q <= 1'b1;
      rts_q <= 1'b0;
      abort_q <= 1'b0;
    end else begin
      tst_q <= tst_d;
      tsh_q <= tsh_d;
      tbit_q <= tbit_d;
      tdiv_q <= tdiv_d;
      tlast_q <= tlast_d;
      txd_q <= txd_d;
      rts_q <= rts_d;
      abort_q <= abort_d;
    end
  end

  assign txd = txd_q;
  assign rts = rts_q;
  assign tx_abort = abort_q;

  // receiver bit engine
  csp_rx_type rst_q, rst_d;
  logic [17:0] rdiv_q, rdiv_d;
  logic [3:0] rbit_q, rbit_d;
  logic [10:0] rsh_q, rsh_d;
  logic ch_ev;
  logic [7:0] ch;
  logic ch_perr;

  assign ch = rsh_q[7:0] & dmask;

  always_comb begin
    rst_d = rst_q;
    rdiv_d = rdiv_q;
    rbit_d = rbit_q;
    rsh_d = rsh_q;
    ch_ev = 1'b0;
    case (rst_q)
      R_IDLE: begin
        if (active && !rxd) begin
          rdiv_d = {1'b0, bit_div[17:1]};
          rst_d = R_START;
        end
      end
      R_START: begin
        if (rdiv_q != 18'h0_0000) begin
          rdiv_d = rdiv_q - 18'h0_0001;
        end else if (rxd) begin
          rst_d = R_IDLE;
        end else begin
          rdiv_d = bit_div - 18'h0_0001;
          rbit_d = 4'h0;
          rst_d = R_BITS;
        end
      end
      R_BITS: begin
        if (rdiv_q != 18'h0_0000) begin
          rdiv_d = rdiv_q - 18'h0_0001;
        end else if (rbit_q == nbits + {3'h0, par_on}) begin
          ch_ev = 1'b1;
          rst_d = R_IDLE;
        end else begin
          rsh_d[rbit_q] = rxd;
          rbit_d = rbit_q + 4'h1;
          rdiv_d = bit_div - 18'h0_0001;
        end
      end
      default: rst_d = R_IDLE;
    endcase
  end
  assign ch_perr = par_on && rsh_q[nbits] != par_bit(ch, parity);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_q <= R_IDLE;
      rdiv_q <= 18'h0_0000;
      rbit_q <= 4'h0;
      rsh_q <= 11'h000;
    end else begin
      rst_q <= rst_d;
      rdiv_q <= rdiv_d;
      rbit_q <= rbit_d;
      rsh_q <= rsh_d;
    end
  end

  // termination character match
  logic [NUM_TERM-1:0] term_hit;
  for (genvar gi = 0; gi < NUM_TERM; gi++) begin : g_term
    assign term_hit[gi] = 16'(gi) < cfg_q[A_TERM_CNT] &&
      cfg_q[A_TERM0 + 5'(gi / 2)][(gi % 2) * 8 +: 8] == ch;
  end

  // message framing
  logic mto_start, mto_exp, gap_start, gap_exp, msg_stop;
  logic [15:0] rcnt_q, rcnt_d, rcnt_inc;
  logic rxv_q, rxv_d, rend_q, rend_d, perr_q, perr_d, end_now;
  logic [7:0] rxdat_q, rxdat_d;

  csp_ms_timer #(.CYC_PER_MS(CYC_PER_MS_P)) u_mto (
    .clk(clk), .resetn(resetn), .start(mto_start), .stop(msg_stop),
    .ms(cfg_q[A_RX_TIMEOUT]), .expired(mto_exp)
  );
  csp_ms_timer #(.CYC_PER_MS(CYC_PER_MS_P)) u_gap (
    .clk(clk), .resetn(resetn), .start(gap_start), .stop(msg_stop),
    .ms(cfg_q[A_RX_GAP]), .expired(gap_exp)
  );

  assign rcnt_inc = rcnt_q + 16'h0001;

  always_comb begin
    rcnt_d = rcnt_q;
    rxv_d = 1'b0;
    rend_d = 1'b0;
    perr_d = 1'b0;
    rxdat_d = rxdat_q;
    xoff_d = xoff_q;
    mto_start = 1'b0;
    gap_start = 1'b0;
    msg_stop = 1'b0;
    end_now = 1'b0;
    if (!active) begin
      rcnt_d = 16'h0000;
      msg_stop = 1'b1;
    end else if (ch_ev && flow == FLOW_XON_XOFF && (ch == CH_XON || ch == CH_XOFF)) begin
      xoff_d = ch == CH_XOFF;
    end else if (ch_ev) begin
      rxv_d = 1'b1;
      rxdat_d = ch;
      perr_d = ch_perr;
      if (end_sel != 16'h0000) begin
        end_now = (end_sel[SEL_TERM] && |term_hit) ||
          (end_sel[SEL_PKT_LEN] && cfg_q[A_PKT_LEN] != 16'h0000 &&
           rcnt_inc >= cfg_q[A_PKT_LEN]);
        if (end_now) begin
          rend_d = 1'b1;
          rcnt_d = 16'h0000;
          msg_stop = 1'b1;
        end else begin
          rcnt_d = rcnt_inc;
          mto_start = end_sel[SEL_MSG_TO] && rcnt_q == 16'h0000;
          gap_start = end_sel[SEL_GAP_TO];
        end
      end
    end else if (rcnt_q != 16'h0000 && ((end_sel[SEL_MSG_TO] && mto_exp) ||
               (end_sel[SEL_GAP_TO] && gap_exp))) begin
      rend_d = 1'b1;
      rcnt_d = 16'h0000;
      msg_stop = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rcnt_q <= 16'h0000;
      rxv_q <= 1'b0;
      rend_q <= 1'b0;
      perr_q <= 1'b0;
      rxdat_q <= 8'h00;
      xoff_q <= 1'b0;
    end else begin
      rcnt_q <= rcnt_d;
      rxv_q <= rxv_d;
      rend_q <= rend_d;
      perr_q <= perr_d;
      rxdat_q <= rxdat_d;
      xoff_q <= xoff_d;
    end
  end

  assign rx_valid = rxv_q;
  assign rx_data = rxdat_q;
  assign rx_end = rend_q;
  assign rx_parity_err = perr_q;
endmodule

//--- dv/csp_serial_port_checker.sv
`timescale 1ns/1ps
module csp_serial_port_checker (
  input wire logic clk,
  input wire logic resetn,
  input wire logic cfg_we,
  input wire logic [4:0] cfg_addr,
  input wire logic [15:0] cfg_wdata,
  input wire logic [15:0] cfg_rdata,
  input wire logic xfer_done,
  input wire logic xfer_ok,
  input wire logic ports_halted,
  input wire logic rx_valid,
  input wire logic rx_end,
  input wire logic rx_parity_err,
  input wire logic txd,
  input wire logic rts,
  input wire logic dtr
);
  logic [15:0] lim_q, lim_d, cnt_q, cnt_d;
  // shadow of the failure limit and the failed transfer count
  always_comb begin
    lim_d = lim_q;
    cnt_d = cnt_q;
    if (cfg_we && cfg_addr == 5'h00) lim_d = cfg_wdata;
    if (xfer_done) cnt_d = xfer_ok ? 16'h0000 : (&cnt_q ? cnt_q : cnt_q + 16'h0001);
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lim_q <= 16'h0000;
      cnt_q <= 16'h0000;
    end else begin
      lim_q <= lim_d;
      cnt_q <= cnt_d;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence cfg_write_s;
    cfg_we && cfg_addr <= 5'h14 ##1 !cfg_we && $stable(cfg_addr);
  endsequence
  halt_level_a: assert property (ports_halted == (lim_q != 16'h0000 && cnt_q >= lim_q))
    else $error("halt level differs from failure count");
  halt_dtr_a: assert property (ports_halted |-> !dtr)
    else $error("port active while halted");
  resume_ok_a: assert property (xfer_done && xfer_ok |=> !ports_halted)
    else $error("halt kept after good transfer");
  cfg_readback_a: assert property (cfg_write_s |=> cfg_rdata == $past(cfg_wdata, 2))
    else $error("config word read back wrong");
  line_idle_a: assert property (!rts |-> txd)
    else $error("line active without request to send");
  lead_gap_a: assert property ($rose(rts) |-> txd [*2])
    else $error("start bit too soon after request to send");
  start_hold_a: assert property ($fell(txd) |-> !txd [*8])
    else $error("start bit too short");
  rx_par_a: assert property (rx_parity_err |-> rx_valid)
    else $error("parity flag without character");
  rx_active_a: assert property (rx_valid |-> $past(dtr))
    else $error("character taken on inactive port");
  end_pulse_a: assert property (rx_end |=> !rx_end)
    else $error("message end longer than one cycle");
endmodule
bind csp_serial_port csp_serial_port_checker chk_u (.clk, .resetn, .cfg_we, .cfg_addr,
  .cfg_wdata, .cfg_rdata, .xfer_done, .xfer_ok, .ports_halted, .rx_valid, .rx_end,
  .rx_parity_err, .txd, .rts, .dtr);

//--- dv/csp_serial_dev.sv
`timescale 1ns/1ps
module csp_serial_dev (
  input wire logic clk,
  input wire logic txd,
  output logic rxd,
  output logic cts,
  output logic dsr
);
  logic ready = 1'b1;
  initial rxd = 1'b1;
  assign cts = ready;
  assign dsr = ready;
  task automatic bit_out(input logic v, input int bc);
    #1;
    rxd = v;
    repeat (bc) @(posedge clk);
  endtask
  // one frame: start, eight data bits lsb first, optional parity, one stop
  task automatic send(input logic [7:0] d, input int pb, input int bc);
    int i;
    @(posedge clk);
    bit_out(1'b0, bc);
    for (i = 0; i < 8; i++) bit_out(d[i], bc);
    if (pb >= 0) bit_out(pb[0], bc);
    bit_out(1'b1, bc);
  endtask
  task automatic recv(input int n, input bit par, input int bc, output logic [7:0] d,
                      output logic p, output bit ok);
    int i;
    ok = 0;
    d = 8'h00;
    p = 1'b0;
    for (i = 0; i < 20000 && txd === 1'b1; i++) @(posedge clk);
    if (txd !== 1'b0) return;
    repeat (bc / 2) @(posedge clk);
    for (i = 0; i < n; i++) begin
      repeat (bc) @(posedge clk);
      d[i] = txd;
    end
    if (par) begin
      repeat (bc) @(posedge clk);
      p = txd;
    end
    repeat (bc) @(posedge clk);
    ok = (txd === 1'b1);
  endtask
endmodule

//--- dv/csp_serial_port_tb_top.sv
`timescale 1ns/1ps
module csp_serial_port_tb_top;
  import csp_pkg::*;
  localparam int BC = 217;
  logic clk = 0, resetn = 0, cfg_we = 0, xfer_done = 0, xfer_ok = 0;
  logic tx_valid = 0, tx_last = 0;
  logic [4:0] cfg_addr = 0;
  logic [15:0] cfg_wdata = 0, cfg_rdata;
  logic [7:0] tx_data = 0, rx_data;
  logic ports_halted, tx_ready, tx_abort, rx_valid, rx_end, rx_parity_err;
  logic txd, rxd, rts, cts, dtr, dsr;
  logic [10:0] got_q[$], exp_q[$];
  int n_fail = 0, samples_checked = 0, seed = 88143;
  always #20 clk = ~clk;
  csp_serial_port #(.CYC_PER_MS_P(25)) dut_u (.*);
  csp_serial_dev dev_u (.clk, .txd, .rxd, .cts, .dsr);
  always @(posedge clk) begin
    if (rx_valid === 1'b1 || rx_end === 1'b1)
      got_q.push_back({rx_parity_err, rx_end, rx_valid, rx_valid ? rx_data : 8'h00});
  end
  function automatic logic exp_par(input int code, input logic [7:0] d);
    case (code)
      1: exp_par = ~^d;
      2: exp_par = ^d;
      3: exp_par = 1'b1;
      default: exp_par = 1'b0;
    endcase
  endfunction
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic tmo();
    n_fail++;
    $display("[FAIL] wait expected done seen timeout");
    summarize();
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    #1;
    cfg_we = 1;
    cfg_addr = a;
    cfg_wdata = d;
    @(posedge clk);
    #1;
    cfg_we = 0;
  endtask
  task automatic rd(input logic [4:0] a, output logic [15:0] v);
    @(posedge clk);
    #1;
    cfg_addr = a;
    repeat (2) @(posedge clk);
    v = cfg_rdata;
  endtask
  task automatic xfer(input logic ok);
    @(posedge clk);
    #1;
    xfer_done = 1;
    xfer_ok = ok;
    @(posedge clk);
    #1;
    xfer_done = 0;
  endtask
  task automatic push(input logic [7:0] d, input logic l);
    int i;
    @(posedge clk);
    #1;
    tx_valid = 1;
    tx_data = d;
    tx_last = l;
    for (i = 0; i < 5000; i++) begin
      @(posedge clk);
      if (tx_ready === 1'b1) break;
    end
    if (i == 5000) tmo();
    #1;
    tx_valid = 0;
  endtask
  task automatic sc(input logic [7:0] d, input logic e);
    dev_u.send(d, -1, BC);
    exp_q.push_back({1'b0, e, 1'b1, d});
  endtask
  task automatic cmp_ev(input int w);
    repeat (w) @(posedge clk);
    chk("rx events", 16'(exp_q.size()), 16'(got_q.size()));
    while (exp_q.size() > 0 && got_q.size() > 0) chk("rx event", exp_q.pop_front(), got_q.pop_front());
    exp_q.delete();
    got_q.delete();
  endtask
  initial begin
    logic [15:0] v, w;
    logic [7:0] g;
    logic p;
    bit ok;
    int i, k, n, e;
    repeat (12) @(posedge clk);
    #1;
    resetn = 1;
    for (i = 0; i < 21; i++) begin
      rd(i[4:0], v);
      chk("reset word", i == 3 ? 16'h2580 : i == 5 ? 16'h0008 : i == 6 ? 16'h0001 : 16'h0000, v);
    end
    for (i = 7; i < 22; i++) begin
      w = 16'($random(seed));
      wr(i[4:0], w);
      rd(i[4:0], v);
      chk("word readback", i == 21 ? 16'h0000 : w, v);
      wr(i[4:0], 16'h0000);
    end
    wr(A_RATE, 16'h0073);
    wr(A_ENABLE, 16'h0000);
    chk("dtr off", 16'h0000, 16'(dtr));
    wr(A_ENABLE, EN_ON);
    chk("dtr on", 16'h0001, 16'(dtr));
    wr(A_FAIL_LIMIT, 16'h0002);
    xfer(0);
    xfer(0);
    chk("halted", 16'h0001, 16'(ports_halted));
    xfer(1);
    chk("resumed", 16'h0000, 16'(ports_halted));
    wr(A_FAIL_LIMIT, 16'h0000);
    for (i = 0; i < 3; i++) xfer(0);
    chk("limit zero", 16'h0000, 16'(ports_halted));
    $display("test config and failure limit done");
    for (k = 0; k < 5; k++) begin
      n = 5 + k % 4;
      wr(A_PARITY, 16'(k));
      wr(A_DATA_BITS, 16'(n));
      w = 16'($random(seed)) & ~(16'hffff << n);
      push(w[7:0], 1'b1);
      dev_u.recv(n, k != 0, BC, g, p, ok);
      if (!ok) tmo();
      chk("tx data", w, 16'(g));
      chk("tx parity", 16'(exp_par(k, w[7:0])), 16'(p));
      for (i = 0; i < 3000 && rts !== 1'b0; i++) @(posedge clk);
      if (rts !== 1'b0) tmo();
    end
    wr(A_PARITY, PAR_NONE);
    wr(A_DATA_BITS, 16'h0008);
    $display("test frame format done");
    wr(A_RATE, 16'he100);
    wr(A_RTS_LEAD, 16'h0002);
    wr(A_RTS_TRAIL, 16'h0002);
    for (k = 1; k < 3; k++) begin
      wr(A_STOP_BITS, 16'(k));
      push(8'h3c, 1'b0);
      push(8'hc3, 1'b1);
      for (i = 0; i < 300 && rts !== 1'b1; i++) @(posedge clk);
      for (n = 0; n < 300 && txd !== 1'b0; n++) @(posedge clk);
      chk("lead window", 16'h0001, 16'(n >= 50 && n <= 54));
      dev_u.recv(8, 1'b0, 2 * BC, g, p, ok);
      chk("rate char", 16'h003c, 16'(g));
      repeat (2 * BC) @(posedge clk);
      chk("second stop", 16'(k == 2), 16'(txd));
      e = (k == 1 ? 19 : 23) * BC + 50;
      for (n = 0; n < 20000 && rts !== 1'b0; n++) @(posedge clk);
      chk("trail window", 16'h0001, 16'(n >= e - 2 && n <= e + 8));
    end
    wr(A_RATE, 16'h0073);
    wr(A_RTS_LEAD, 16'h0000);
    wr(A_RTS_TRAIL, 16'h0000);
    wr(A_STOP_BITS, 16'h0001);
    $display("test request to send timing done");
    for (k = 1; k < 4; k++) begin
      wr(A_FLOW, 16'(k));
      if (k == 3) dev_u.send(CH_XOFF, -1, BC);
      else dev_u.ready = 0;
      push(8'ha5, 1'b1);
      for (i = 0; i < 600 && txd === 1'b1; i++) @(posedge clk);
      chk("held by flow", 16'd600, 16'(i));
      if (k == 3) dev_u.send(CH_XON, -1, BC);
      else dev_u.ready = 1;
      dev_u.recv(8, 1'b0, BC, g, p, ok);
      chk("flow char", 16'h00a5, 16'(g));
    end
    cmp_ev(20);
    wr(A_FLOW, 16'h0000);
    wr(A_TX_TIMEOUT, 16'h0001);
    push(8'h11, 1'b0);
    push(8'h22, 1'b0);
    push(8'h33, 1'b1);
    dev_u.recv(8, 1'b0, BC, g, p, ok);
    for (i = 0; i < 3000 && tx_abort !== 1'b1; i++) @(posedge clk);
    chk("abort seen", 16'h0001, 16'(i < 3000));
    for (i = 0; i < 3000 && txd === 1'b1; i++) @(posedge clk);
    chk("rest dropped", 16'd3000, 16'(i));
    wr(A_TX_TIMEOUT, 16'h0000);
    $display("test flow and abort done");
    sc(8'h41, 0);
    sc(8'h0d, 0);
    cmp_ev(20);
    wr(A_TERM0, 16'h0a0d);
    wr(A_TERM_CNT, 16'h0001);
    wr(A_END_SEL, 16'h0001);
    sc(8'h0a, 0);
    sc(8'h0d, 1);
    wr(A_TERM_CNT, 16'h0002);
    sc(8'h41, 0);
    sc(8'h0a, 1);
    cmp_ev(20);
    wr(A_PKT_LEN, 16'h0003);
    wr(A_END_SEL, 16'h0009);
    for (i = 1; i < 5; i++) sc(i[7:0], i == 3);
    sc(8'h0d, 1);
    cmp_ev(20);
    wr(A_RX_GAP, 16'd200);
    wr(A_END_SEL, 16'h0004);
    sc(8'h05, 0);
    sc(8'h06, 0);
    exp_q.push_back(11'h200);
    cmp_ev(5300);
    wr(A_RX_TIMEOUT, 16'd100);
    wr(A_END_SEL, 16'h0002);
    sc(8'h07, 0);
    sc(8'h08, 0);
    exp_q.push_back(11'h200);
    cmp_ev(2000);
    wr(A_END_SEL, 16'h0000);
    wr(A_PARITY, PAR_EVEN);
    dev_u.send(8'h01, 0, BC);
    exp_q.push_back(11'h501);
    cmp_ev(20);
    $display("test receive end conditions done");
    summarize();
  end
endmodule
